// >>> pkg/branch_exec_pkg.sv
package branch_exec_pkg;

    // Operation selector
    typedef enum logic [4:0] {
        OP_NOP, OP_XOR, OP_OR, OP_CPA, OP_ROL, OP_ROR, OP_RCL, OP_RCR,
        OP_INV, OP_TOGC, OP_SETC, OP_JP, OP_JCOND, OP_CALL, OP_CCOND,
        OP_RTN, OP_RCOND, OP_VCALL, OP_JHL, OP_PUSH
    } op_t;

    // Operand source
    typedef enum logic [1:0] {
        SRC_REG, SRC_MEM, SRC_IMM
    } src_t;

    // Condition flags
    typedef struct packed {
        logic sign;
        logic zero;
        logic half_carry_flag;
        logic parity;
        logic carry_flag;
    } flags_t;

    // Issued instruction
    typedef struct packed {
        op_t op;
        src_t src;
        logic [2:0] condition_select_field;
        logic [2:0] vector_number_field;
        logic [7:0] reg_operand;
        logic [7:0] imm_lo;
        logic [7:0] imm_hi;
        logic [7:0] push_hi;
        logic [7:0] push_lo;
    } instr_t;

    // Clock states per instruction form
    localparam logic [4:0] ST_REG_OP = 5'h04;
    localparam logic [4:0] ST_MEM_OP = 5'h07;
    localparam logic [4:0] ST_JP = 5'h0a;
    localparam logic [4:0] ST_JCOND_SKIP = 5'h07;
    localparam logic [4:0] ST_CALL = 5'h12;
    localparam logic [4:0] ST_CCOND_SKIP = 5'h09;
    localparam logic [4:0] ST_RTN = 5'h0a;
    localparam logic [4:0] ST_RCOND_SKIP = 5'h06;
    localparam logic [4:0] ST_RCOND_TAKEN = 5'h0c;
    localparam logic [4:0] ST_VCALL = 5'h0c;
    localparam logic [4:0] ST_JHL = 5'h06;
    localparam logic [4:0] ST_PUSH = 5'h0c;

    // Reset values
    localparam logic [15:0] PC_RESET = 16'h0000;
    localparam logic [15:0] SP_RESET = 16'h0000;
    localparam logic [7:0] ACC_RESET = 8'h00;

endpackage

// >>> logic/branch_exec.sv
`timescale 1ns/1ps
// Overview of operation
// RULE_01 - XOR operand into accumulator, clear carry and half carry.
// RULE_02 - OR operand into accumulator, clear carry and half carry; register form 4 states.
// RULE_03 - Compare subtracts operand, sets flags, keeps accumulator.
// RULE_04 - Compare: zero when equal, carry when accumulator below operand.
// RULE_05 - Rotate left circular: bit 7 to bit 0 and carry; 4 states.
// RULE_06 - Rotate right circular: bit 0 to bit 7 and carry only.
// RULE_07 - Rotate left through carry; only carry changes.
// RULE_08 - Rotate right through carry; only carry changes.
// RULE_09 - Invert accumulator, flags untouched.
// RULE_10 - Toggle carry inverts carry; set carry forces one; nothing else.
// RULE_11 - Branch instructions never change condition flags.
// RULE_12 - Condition code selects zero, carry, parity or sign, clear or set.
// RULE_13 - Unconditional jump loads high byte three, low byte two; 10 states.
// RULE_14 - Conditional jump only when condition holds; 7 skipped, 10 taken.
// RULE_15 - Call pushes high then low return byte, SP minus 2, jumps.
// RULE_16 - Conditional call only when condition true; else sequential.
// RULE_17 - Return pops low then high PC byte, SP plus 2; 10 states.
// RULE_18 - Conditional return only when condition true; else sequential.
// RULE_19 - Vector call pushes like call, then PC is eight times vector.
// RULE_20 - Pointer-pair jump copies H high and L low into PC.
// RULE_21 - Pair push stores high at SP-1, low at SP-2, SP minus 2.
// RULE_22 - Logical group updates zero, sign, parity, half carry, carry.
// RULE_23 - Subtraction is two's complement, carry marks borrow.
// RULE_24 - Each instruction completes in its listed number of clock states.
module branch_exec (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Instruction issue
    input wire logic issue_valid,
    input wire branch_exec_pkg::instr_t issue_instr,
    input wire logic [7:0] reg_h,
    input wire logic [7:0] reg_l,
    output logic busy,
    output logic done,
    // Memory bus
    output logic mem_rd,
    output logic mem_wr,
    output logic [15:0] mem_addr,
    output logic [7:0] mem_wdata,
    input wire logic [7:0] mem_rdata,
    // Architectural state
    output logic [7:0] acc,
    output branch_exec_pkg::flags_t flags,
    output logic [15:0] pc,
    output logic [15:0] sp
);

    typedef enum logic [2:0] {S_IDLE, S_WR_HI, S_WR_LO, S_RD_LO, S_RD_HI, S_WAIT} state_t;

    state_t state_reg, state_next;
    logic [7:0] acc_reg, acc_next;
    branch_exec_pkg::flags_t flags_reg, flags_next;
    logic [15:0] pc_reg, pc_next, sp_reg, sp_next;
    logic [15:0] target_reg, target_next;
    logic [7:0] push_hi_reg, push_lo_reg, push_hi_next, push_lo_next, rd_lo_reg, rd_lo_next;
    logic [4:0] cnt_reg, cnt_next;
    logic busy_reg, done_reg, done_next;
    logic mem_rd_reg, mem_wr_reg, mem_rd_next, mem_wr_next;
    logic [15:0] mem_addr_reg, mem_addr_next;
    logic [7:0] mem_wdata_reg, mem_wdata_next;

    // ------------------------------------------------------------
    // Operand, condition and ALU decode
    // ------------------------------------------------------------
    wire logic [7:0] operand = (issue_instr.src == branch_exec_pkg::SRC_REG) ? issue_instr.reg_operand :
                               (issue_instr.src == branch_exec_pkg::SRC_MEM) ? mem_rdata : issue_instr.imm_lo;
    wire logic [8:0] diff = {1'b0, acc_reg} - {1'b0, operand};                // RULE_23
    wire logic [7:0] xor_res = acc_reg ^ operand;
    wire logic [7:0] or_res = acc_reg | operand;
    wire logic [4:0] half_diff = {1'b0, acc_reg[3:0]} - {1'b0, operand[3:0]};
    wire logic [2:0] cond_sel = issue_instr.condition_select_field;
    wire logic [3:0] cond_src = {flags_reg.sign, flags_reg.parity, flags_reg.carry_flag, flags_reg.zero};
    wire logic cond_true = (cond_src[cond_sel[2:1]] == cond_sel[0]);           // RULE_12
    wire logic [15:0] imm_addr = {issue_instr.imm_hi, issue_instr.imm_lo};     // RULE_13
    wire logic [15:0] vec_addr = {10'h000, issue_instr.vector_number_field, 3'h0}; // RULE_19
    wire logic [15:0] sp_m1 = sp_reg - 16'h0001;
    wire logic [15:0] sp_m2 = sp_reg - 16'h0002;
    wire logic [15:0] sp_p1 = sp_reg + 16'h0001;
    wire logic [15:0] sp_p2 = sp_reg + 16'h0002;

    function automatic branch_exec_pkg::flags_t logic_flags(input logic [7:0] r);
        branch_exec_pkg::flags_t f;
        f.sign = r[7];
        f.zero = (r == 8'h00);
        f.parity = ~^r;
        f.half_carry_flag = 1'b0;
        f.carry_flag = 1'b0;
        return f;
    endfunction

    // ------------------------------------------------------------
    // Next state and data path
    // ------------------------------------------------------------
    always_comb begin
        state_next = state_reg;
        acc_next = acc_reg;
        flags_next = flags_reg;
        pc_next = pc_reg;
        sp_next = sp_reg;
        target_next = target_reg;
        push_hi_next = push_hi_reg;
        push_lo_next = push_lo_reg;
        rd_lo_next = rd_lo_reg;
        cnt_next = cnt_reg;
        done_next = 1'b0;
        mem_rd_next = 1'b0;
        mem_wr_next = 1'b0;
        mem_addr_next = mem_addr_reg;
        mem_wdata_next = mem_wdata_reg;
        unique case (state_reg)
            S_IDLE: begin
                if (issue_valid) begin
                    cnt_next = branch_exec_pkg::ST_REG_OP - 5'h01;
                    state_next = S_WAIT;
                    unique case (issue_instr.op)
                        branch_exec_pkg::OP_XOR: begin
                            acc_next = xor_res;                                 // RULE_01
                            flags_next = logic_flags(xor_res);                  // RULE_22
                        end
                        branch_exec_pkg::OP_OR: begin
                            acc_next = or_res;                                  // RULE_02
                            flags_next = logic_flags(or_res);                   // RULE_22
                        end
                        branch_exec_pkg::OP_CPA: begin
                            flags_next.zero = (diff[7:0] == 8'h00);             // RULE_04
                            flags_next.carry_flag = diff[8];                    // RULE_04
                            flags_next.sign = diff[7];                          // RULE_03
                            flags_next.parity = ~^diff[7:0];
                            flags_next.half_carry_flag = ~half_diff[4];
                        end
                        branch_exec_pkg::OP_ROL: begin
                            acc_next = {acc_reg[6:0], acc_reg[7]};              // RULE_05
                            flags_next.carry_flag = acc_reg[7];
                        end
                        branch_exec_pkg::OP_ROR: begin
                            acc_next = {acc_reg[0], acc_reg[7:1]};              // RULE_06
                            flags_next.carry_flag = acc_reg[0];
                        end
                        branch_exec_pkg::OP_RCL: begin
                            acc_next = {acc_reg[6:0], flags_reg.carry_flag};    // RULE_07
                            flags_next.carry_flag = acc_reg[7];
                        end
                        branch_exec_pkg::OP_RCR: begin
                            acc_next = {flags_reg.carry_flag, acc_reg[7:1]};    // RULE_08
                            flags_next.carry_flag = acc_reg[0];
                        end
                        branch_exec_pkg::OP_INV: acc_next = ~acc_reg;           // RULE_09
                        branch_exec_pkg::OP_TOGC: flags_next.carry_flag = ~flags_reg.carry_flag; // RULE_10
                        branch_exec_pkg::OP_SETC: flags_next.carry_flag = 1'b1; // RULE_10
                        branch_exec_pkg::OP_JP: begin
                            pc_next = imm_addr;                                 // RULE_13
                            cnt_next = branch_exec_pkg::ST_JP - 5'h01;
                        end
                        branch_exec_pkg::OP_JCOND: begin
                            if (cond_true) begin
                                pc_next = imm_addr;                             // RULE_14
                                cnt_next = branch_exec_pkg::ST_JP - 5'h01;
                            end else begin
                                cnt_next = branch_exec_pkg::ST_JCOND_SKIP - 5'h01;
                            end
                        end
                        branch_exec_pkg::OP_CALL, branch_exec_pkg::OP_CCOND,
                        branch_exec_pkg::OP_VCALL, branch_exec_pkg::OP_PUSH: begin
                            push_hi_next = pc_reg[15:8];
                            push_lo_next = pc_reg[7:0];
                            target_next = (issue_instr.op == branch_exec_pkg::OP_VCALL) ? vec_addr : imm_addr;
                            if (issue_instr.op == branch_exec_pkg::OP_PUSH) begin
                                push_hi_next = issue_instr.push_hi;              // RULE_21
                                push_lo_next = issue_instr.push_lo;
                                target_next = pc_reg;
                            end
                            cnt_next = (issue_instr.op == branch_exec_pkg::OP_CALL ||
                                        issue_instr.op == branch_exec_pkg::OP_CCOND) ?
                                       branch_exec_pkg::ST_CALL - 5'h03 : branch_exec_pkg::ST_PUSH - 5'h03;
                            if (issue_instr.op == branch_exec_pkg::OP_CCOND && !cond_true) begin
                                cnt_next = branch_exec_pkg::ST_CCOND_SKIP - 5'h01; // RULE_16
                            end else begin
                                state_next = S_WR_HI;                           // RULE_15
                                mem_wr_next = 1'b1;
                                mem_addr_next = sp_m1;
                                mem_wdata_next = push_hi_next;
                            end
                        end
                        branch_exec_pkg::OP_RTN, branch_exec_pkg::OP_RCOND: begin
                            if (issue_instr.op == branch_exec_pkg::OP_RCOND && !cond_true) begin
                                cnt_next = branch_exec_pkg::ST_RCOND_SKIP - 5'h01; // RULE_18
                            end else begin
                                state_next = S_RD_LO;                           // RULE_17
                                mem_rd_next = 1'b1;
                                mem_addr_next = sp_reg;
                                cnt_next = ((issue_instr.op == branch_exec_pkg::OP_RTN) ?
                                            branch_exec_pkg::ST_RTN : branch_exec_pkg::ST_RCOND_TAKEN) - 5'h03;
                            end
                        end
                        branch_exec_pkg::OP_JHL: begin
                            pc_next = {reg_h, reg_l};                           // RULE_20
                            cnt_next = branch_exec_pkg::ST_JHL - 5'h01;
                        end
                        default: ;
                    endcase
                    if (issue_instr.src != branch_exec_pkg::SRC_REG && issue_instr.op inside
                        {branch_exec_pkg::OP_XOR, branch_exec_pkg::OP_OR, branch_exec_pkg::OP_CPA}) begin
                        cnt_next = branch_exec_pkg::ST_MEM_OP - 5'h01;          // RULE_24
                    end
                end
            end
            S_WR_HI: begin
                mem_wr_next = 1'b1;                                             // RULE_21
                mem_addr_next = sp_m2;
                mem_wdata_next = push_lo_reg;
                state_next = S_WR_LO;
            end
            S_WR_LO: begin
                sp_next = sp_m2;                                                // RULE_15
                pc_next = target_reg;
                state_next = S_WAIT;
            end
            S_RD_LO: begin
                rd_lo_next = mem_rdata;
                mem_rd_next = 1'b1;
                mem_addr_next = sp_p1;
                state_next = S_RD_HI;
            end
            S_RD_HI: begin
                pc_next = {mem_rdata, rd_lo_reg};                               // RULE_17
                sp_next = sp_p2;
                state_next = S_WAIT;
            end
            S_WAIT: begin
                if (cnt_reg <= 5'h01) begin
                    done_next = 1'b1;                                           // RULE_24
                    state_next = S_IDLE;
                end else begin
                    cnt_next = cnt_reg - 5'h01;
                end
            end
            default: state_next = S_IDLE;
        endcase
    end

    // ------------------------------------------------------------
    // State registers
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (rst) begin
            state_reg <= S_IDLE;
            acc_reg <= branch_exec_pkg::ACC_RESET;
            flags_reg <= '0;
            pc_reg <= branch_exec_pkg::PC_RESET;
            sp_reg <= branch_exec_pkg::SP_RESET;
            target_reg <= 16'h0000;
            push_hi_reg <= 8'h00;
            push_lo_reg <= 8'h00;
            rd_lo_reg <= 8'h00;
            cnt_reg <= 5'h00;
            busy_reg <= 1'b0;
            done_reg <= 1'b0;
            mem_rd_reg <= 1'b0;
            mem_wr_reg <= 1'b0;
            mem_addr_reg <= 16'h0000;
            mem_wdata_reg <= 8'h00;
        end else begin
            state_reg <= state_next;
            acc_reg <= acc_next;
            flags_reg <= flags_next;
            pc_reg <= pc_next;
            sp_reg <= sp_next;
            target_reg <= target_next;
            push_hi_reg <= push_hi_next;
            push_lo_reg <= push_lo_next;
            rd_lo_reg <= rd_lo_next;
            cnt_reg <= cnt_next;
            busy_reg <= (state_next != S_IDLE);
            done_reg <= done_next;
            mem_rd_reg <= mem_rd_next;
            mem_wr_reg <= mem_wr_next;
            mem_addr_reg <= mem_addr_next;
            mem_wdata_reg <= mem_wdata_next;
        end
    end

    // Outputs straight from flops
    assign busy = busy_reg;
    assign done = done_reg;
    assign mem_rd = mem_rd_reg;
    assign mem_wr = mem_wr_reg;
    assign mem_addr = mem_addr_reg;
    assign mem_wdata = mem_wdata_reg;
    assign acc = acc_reg;
    assign flags = flags_reg;
    assign pc = pc_reg;
    assign sp = sp_reg;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    wire logic is_issue = (state_reg == S_IDLE) && issue_valid;
    wire logic is_branch = issue_instr.op inside {branch_exec_pkg::OP_JP, branch_exec_pkg::OP_JCOND,
        branch_exec_pkg::OP_CALL, branch_exec_pkg::OP_CCOND, branch_exec_pkg::OP_RTN,
        branch_exec_pkg::OP_RCOND, branch_exec_pkg::OP_VCALL, branch_exec_pkg::OP_JHL};

    a_xor_clears_carry: assert property (@(posedge clk) disable iff (rst) // RULE_01
        is_issue && issue_instr.op == branch_exec_pkg::OP_XOR |=> !flags.carry_flag && !flags.half_carry_flag
        && acc == ($past(acc) ^ $past(operand))) else $error("xor result or flags wrong");
    a_or_result: assert property (@(posedge clk) disable iff (rst) // RULE_02
        is_issue && issue_instr.op == branch_exec_pkg::OP_OR |=> acc == ($past(acc) | $past(operand))
        && !flags.carry_flag) else $error("or result wrong");
    a_cpa_keeps_acc: assert property (@(posedge clk) disable iff (rst) // RULE_03
        is_issue && issue_instr.op == branch_exec_pkg::OP_CPA |=> $stable(acc)) else $error("compare changed acc");
    a_cpa_flags: assert property (@(posedge clk) disable iff (rst) // RULE_04
        is_issue && issue_instr.op == branch_exec_pkg::OP_CPA |=> flags.zero == ($past(acc) == $past(operand))
        && flags.carry_flag == ($past(acc) < $past(operand))) else $error("compare flags wrong");
    a_rol_rotate: assert property (@(posedge clk) disable iff (rst) // RULE_05
        is_issue && issue_instr.op == branch_exec_pkg::OP_ROL |=> acc == {$past(acc[6:0]), $past(acc[7])}
        && flags.carry_flag == $past(acc[7]) && flags.zero == $past(flags.zero)) else $error("rol wrong");
    a_rcr_rotate: assert property (@(posedge clk) disable iff (rst) // RULE_08
        is_issue && issue_instr.op == branch_exec_pkg::OP_RCR |=> acc == {$past(flags.carry_flag), $past(acc[7:1])})
        else $error("rcr wrong");
    a_branch_flags_kept: assert property (@(posedge clk) disable iff (rst) // RULE_11
        is_issue && is_branch |=> $stable(flags)) else $error("branch changed flags");
    a_rtn_sp_step: assert property (@(posedge clk) disable iff (rst) // RULE_17
        is_issue && issue_instr.op == branch_exec_pkg::OP_RTN |=> ##2 sp == $past(sp, 3) + 16'h0002)
        else $error("return sp wrong");
    a_jp_timing: assert property (@(posedge clk) disable iff (rst) // RULE_13
        is_issue && issue_instr.op == branch_exec_pkg::OP_JP |=> !done [*8] ##1 !done ##1 done)
        else $error("jump time wrong");

endmodule

// >>> dv/stack_mem_model.sv
`timescale 1ns/1ps
// Program and stack memory behind the bus
module stack_mem_model (
    // Clock
    input wire logic clk,
    // Memory bus
    input wire logic mem_rd,
    input wire logic mem_wr,
    input wire logic [15:0] mem_addr,
    input wire logic [7:0] mem_wdata,
    output logic [7:0] mem_rdata,
    // Operand already fetched through H/L
    input wire logic oper_en,
    input wire logic [7:0] oper_byte
);
    logic [7:0] mem [0:65535];
    logic [7:0] idle_q = 8'h00;
    // Address-derived fill
    initial begin
        for (int k = 0; k < 65536; k++) begin
            mem[k] = 8'(k) ^ 8'(k >> 8) ^ 8'h5a;
        end
    end
    // Writes land at the edge; reads answer while the strobe stands
    always @(posedge clk) begin
        if (mem_wr) begin
            mem[mem_addr] <= mem_wdata;
        end
        idle_q <= ~mem_rdata;
    end
    // Idle bus toggles so stale data never looks valid
    assign mem_rdata = oper_en ? oper_byte : (mem_rd ? mem[mem_addr] : idle_q);
endmodule

// >>> dv/tb_top.sv
`timescale 1ns/1ps
module tb_top;
    // ------------------------------
    // Stimulus, outputs and shadow state
    // ------------------------------
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic issue_valid = 1'b0;
    branch_exec_pkg::instr_t issue_instr = '0;
    logic [7:0] reg_h = 8'h00;
    logic [7:0] reg_l = 8'h00;
    logic oper_en = 1'b0;
    logic [7:0] oper_byte = 8'h00;
    logic busy, done, mem_rd, mem_wr;
    logic [15:0] mem_addr, pc, sp;
    logic [7:0] mem_wdata, mem_rdata, acc;
    branch_exec_pkg::flags_t flags;
    int n_errors = 0;
    int checks_done = 0;
    int cyc = 0;
    int issue_cyc = 0;
    logic [31:0] seed = 32'h000109ad;
    logic [7:0] e_acc = 8'h00;
    branch_exec_pkg::flags_t e_fl = '0;
    logic [15:0] e_pc = 16'h0000;
    logic [15:0] e_sp = 16'h0000;
    logic [50:0] state_q[$];
    logic [23:0] write_q[$];

    branch_exec branch_exec_inst (.clk(clk), .rst(rst), .issue_valid(issue_valid), .issue_instr(issue_instr),
        .reg_h(reg_h), .reg_l(reg_l), .busy(busy), .done(done), .mem_rd(mem_rd), .mem_wr(mem_wr),
        .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata), .acc(acc), .flags(flags),
        .pc(pc), .sp(sp));
    stack_mem_model stack_mem_model_inst (.clk(clk), .mem_rd(mem_rd), .mem_wr(mem_wr), .mem_addr(mem_addr),
        .mem_wdata(mem_wdata), .mem_rdata(mem_rdata), .oper_en(oper_en), .oper_byte(oper_byte));

    // Clock and hang guard
    initial forever #20 clk = ~clk;
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc >= 20000) begin
            n_errors++;
            summarize();
        end
    end

    // ------------------------------
    // Helpers
    // ------------------------------
    function automatic logic [7:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed[7:0];
    endfunction
    function automatic branch_exec_pkg::flags_t szp(input logic [7:0] r, input logic hc, input logic cf);
        return {r[7], r == 8'h00, hc, ~^r, cf};
    endfunction
    function automatic logic cond(input logic [2:0] c);
        logic [3:0] f;
        f = {e_fl.sign, e_fl.parity, e_fl.carry_flag, e_fl.zero};
        return f[c[2:1]] == c[0];
    endfunction
    task automatic push2(input logic [7:0] hi, input logic [7:0] lo);
        write_q.push_back({e_sp - 16'h0001, hi});
        write_q.push_back({e_sp - 16'h0002, lo});
        e_sp = e_sp - 16'h0002;
    endtask
    task automatic chk_state(input logic [50:0] got, input logic [50:0] exp);
        checks_done++;
        if (got !== exp) begin
            n_errors++;
            $display("Error t=%0t state got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic chk_write(input logic [23:0] got, input logic [23:0] exp);
        checks_done++;
        if (got !== exp) begin
            n_errors++;
            $display("Error t=%0t write got %h exp %h", $time, got, exp);
        end
    endtask

    // Note expectations, issue, await done
    task automatic run(input branch_exec_pkg::op_t op, input branch_exec_pkg::src_t src, input logic [2:0] c,
                       input logic [7:0] b);
        branch_exec_pkg::instr_t i;
        logic [7:0] a, r, h, l;
        logic [4:0] st;
        logic t;
        int n;
        a = e_acc;
        h = rnd();
        l = rnd();
        t = cond(c);
        i = '0;
        i.op = op;
        i.src = src;
        i.condition_select_field = c;
        i.vector_number_field = c;
        i.reg_operand = (src == branch_exec_pkg::SRC_REG) ? b : ~b;
        i.imm_lo = (src == branch_exec_pkg::SRC_IMM) ? b : ~b;
        i.imm_hi = rnd();
        i.push_hi = rnd();
        i.push_lo = rnd();
        st = (src != branch_exec_pkg::SRC_REG && op <= branch_exec_pkg::OP_CPA) ? branch_exec_pkg::ST_MEM_OP :
             branch_exec_pkg::ST_REG_OP;
        case (op)
            branch_exec_pkg::OP_XOR: r = a ^ b;
            branch_exec_pkg::OP_OR: r = a | b;
            branch_exec_pkg::OP_ROL: r = {a[6:0], a[7]};
            branch_exec_pkg::OP_ROR: r = {a[0], a[7:1]};
            branch_exec_pkg::OP_RCL: r = {a[6:0], e_fl.carry_flag};
            branch_exec_pkg::OP_RCR: r = {e_fl.carry_flag, a[7:1]};
            branch_exec_pkg::OP_INV: r = ~a;
            default: r = a;
        endcase
        case (op)
            branch_exec_pkg::OP_XOR, branch_exec_pkg::OP_OR: e_fl = szp(r, 1'b0, 1'b0);
            branch_exec_pkg::OP_CPA: e_fl = szp(a - b, a[3:0] >= b[3:0], a < b);
            branch_exec_pkg::OP_ROL, branch_exec_pkg::OP_RCL: e_fl.carry_flag = a[7];
            branch_exec_pkg::OP_ROR, branch_exec_pkg::OP_RCR: e_fl.carry_flag = a[0];
            branch_exec_pkg::OP_TOGC: e_fl.carry_flag = ~e_fl.carry_flag;
            branch_exec_pkg::OP_SETC: e_fl.carry_flag = 1'b1;
            default: ;
        endcase
        e_acc = r;
        if (op == branch_exec_pkg::OP_JP || (op == branch_exec_pkg::OP_JCOND && t)) begin
            e_pc = {i.imm_hi, i.imm_lo};
            st = branch_exec_pkg::ST_JP;
        end else if (op == branch_exec_pkg::OP_JCOND) begin
            st = branch_exec_pkg::ST_JCOND_SKIP;
        end else if (op == branch_exec_pkg::OP_CALL || (op == branch_exec_pkg::OP_CCOND && t)) begin
            push2(e_pc[15:8], e_pc[7:0]);
            e_pc = {i.imm_hi, i.imm_lo};
            st = branch_exec_pkg::ST_CALL;
        end else if (op == branch_exec_pkg::OP_CCOND) begin
            st = branch_exec_pkg::ST_CCOND_SKIP;
        end else if (op == branch_exec_pkg::OP_RTN || (op == branch_exec_pkg::OP_RCOND && t)) begin
            e_pc = {stack_mem_model_inst.mem[e_sp + 16'h0001], stack_mem_model_inst.mem[e_sp]};
            e_sp = e_sp + 16'h0002;
            st = (op == branch_exec_pkg::OP_RTN) ? branch_exec_pkg::ST_RTN : branch_exec_pkg::ST_RCOND_TAKEN;
        end else if (op == branch_exec_pkg::OP_RCOND) begin
            st = branch_exec_pkg::ST_RCOND_SKIP;
        end else if (op == branch_exec_pkg::OP_VCALL) begin
            push2(e_pc[15:8], e_pc[7:0]);
            e_pc = {10'h000, c, 3'h0};
            st = branch_exec_pkg::ST_VCALL;
        end else if (op == branch_exec_pkg::OP_JHL) begin
            e_pc = {h, l};
            st = branch_exec_pkg::ST_JHL;
        end else if (op == branch_exec_pkg::OP_PUSH) begin
            push2(i.push_hi, i.push_lo);
            st = branch_exec_pkg::ST_PUSH;
        end
        state_q.push_back({e_acc, e_fl, e_pc, e_sp, st, 1'b0});
        @(posedge clk);
        issue_instr <= i;
        issue_valid <= 1'b1;
        reg_h <= h;
        reg_l <= l;
        oper_en <= (src == branch_exec_pkg::SRC_MEM);
        oper_byte <= b;
        @(posedge clk);
        issue_cyc = cyc;
        issue_valid <= 1'b0;
        oper_en <= 1'b0;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (done !== 1'b1 && n < 40);
        if (n >= 40) begin
            n_errors++;
            $display("Error t=%0t no completion got %h exp %h", $time, n, st);
        end
    endtask

    // Watcher: oldest note against each result
    always @(posedge clk) begin
        if (mem_wr === 1'b1) begin
            chk_write({mem_addr, mem_wdata}, (write_q.size() != 0) ? write_q.pop_front() : 24'hxxxxxx);
        end
        if (done === 1'b1) begin
            chk_state({acc, flags, pc, sp, 5'(cyc - issue_cyc), busy}, state_q.pop_front());
        end
    end

    // Closing report
    task automatic summarize();
        $display("Checks %0d, errors %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // Main sequence
    initial begin
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        for (int k = 0; k < 12; k++) begin
            for (int j = 1; j <= 10; j++) begin
                run(branch_exec_pkg::op_t'(j), branch_exec_pkg::src_t'(k % 3), 3'h0, rnd());
            end
            run(branch_exec_pkg::OP_CPA, branch_exec_pkg::src_t'(k % 3), 3'h0, e_acc);
        end
        for (int c = 0; c < 8; c++) begin
            run(branch_exec_pkg::OP_CPA, branch_exec_pkg::SRC_IMM, 3'h0, rnd());
            for (int j = 11; j <= 19; j++) begin
                run(branch_exec_pkg::op_t'(j), branch_exec_pkg::SRC_REG, 3'(c), rnd());
            end
            run(branch_exec_pkg::OP_RTN, branch_exec_pkg::SRC_REG, 3'h0, 8'h00);
        end
        summarize();
    end
endmodule
